/* rtl/arfwd_core.sv */
// Overview of operation
// - right justified: top bits low, sign-extended differential
// - right justified single-ended: upper six bits zero
// - right justified: low byte holds eight low bits
// - left justified: high byte holds eight top bits
// - left justified: low byte two bits, rest zero
// - single-ended results are unsigned codes
// - differential results are two's complement codes
// - every conversion compared against both limit words
// - match flag polled by software, also interrupt source
// - lower above upper: flag inside band only
// - lower not above upper: flag outside band
// - reset clears data, lower low; upper high ones
// - differential compare uses signed numbers
// - flag stays set until software clears it
// - control bit zero selects left justification
`timescale 1ns/1ns
`default_nettype none

module arfwd_core
  import arfwd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   conv_done,
  input  wire logic [ARFWD_RES_W-1:0] conv_data,
  input  wire logic                   conv_diff,
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic      [7:0]             sfr_rdata,
  output logic                        justify_left_sel,
  output logic                        window_match_flag
);

  logic [7:0]     res_lo_reg;
  logic [7:0]     res_lo_next;
  logic [7:0]     res_hi_reg;
  logic [7:0]     res_hi_next;
  logic [7:0]     upl_lo_reg;
  logic [7:0]     upl_lo_next;
  logic [7:0]     upl_hi_reg;
  logic [7:0]     upl_hi_next;
  logic [7:0]     lwl_lo_reg;
  logic [7:0]     lwl_lo_next;
  logic [7:0]     lwl_hi_reg;
  logic [7:0]     lwl_hi_next;
  logic           just_reg;
  logic           just_next;
  logic           flag_reg;
  logic           flag_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  arfwd_word_type new_word;
  logic           win_match;
  logic           ctrl_wr;
  logic           hit;

  // places a raw result into the sixteen-bit data word
  function automatic arfwd_word_type fmt_word(
    input logic [ARFWD_RES_W-1:0] raw,
    input logic                   left,
    input logic                   diff
  );
    arfwd_word_type w;
    if (left) begin
      w = {raw, {ARFWD_PAD_W{1'b0}}};
    end else if (diff) begin
      w = {{ARFWD_PAD_W{raw[ARFWD_RES_W-1]}}, raw};
    end else begin
      w = {{ARFWD_PAD_W{1'b0}}, raw};
    end
    return w;
  endfunction

  // register index decode shared by read and write paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign new_word = fmt_word(conv_data, just_reg, conv_diff);
  assign ctrl_wr  = sfr_wr && addr_is(sfr_addr, ARFWD_CTRL_ADDR);
  assign hit      = conv_done && win_match;

  arfwd_window_cmp arfwd_window_cmp_inst (
    .data_word   (new_word),
    .upper_limit ({upl_hi_reg, upl_lo_reg}),
    .lower_limit ({lwl_hi_reg, lwl_lo_reg}),
    .signed_cmp  (conv_diff),
    .match       (win_match)
  );

  always_comb begin
    res_lo_next = res_lo_reg;
    res_hi_next = res_hi_reg;
    upl_lo_next = upl_lo_reg;
    upl_hi_next = upl_hi_reg;
    lwl_lo_next = lwl_lo_reg;
    lwl_hi_next = lwl_hi_reg;
    just_next   = just_reg;
    flag_next   = flag_reg;
    rdata_next  = rdata_reg;
    // byte-wide writes from software
    if (sfr_wr) begin
      if (addr_is(sfr_addr, ARFWD_RES_LO_ADDR)) begin
        res_lo_next = sfr_wdata;
      end
      if (addr_is(sfr_addr, ARFWD_RES_HI_ADDR)) begin
        res_hi_next = sfr_wdata;
      end
      if (addr_is(sfr_addr, ARFWD_UPL_LO_ADDR)) begin
        upl_lo_next = sfr_wdata;
      end
      if (addr_is(sfr_addr, ARFWD_UPL_HI_ADDR)) begin
        upl_hi_next = sfr_wdata;
      end
      if (addr_is(sfr_addr, ARFWD_LWL_LO_ADDR)) begin
        lwl_lo_next = sfr_wdata;
      end
      if (addr_is(sfr_addr, ARFWD_LWL_HI_ADDR)) begin
        lwl_hi_next = sfr_wdata;
      end
    end
    if (ctrl_wr) begin
      just_next = sfr_wdata[ARFWD_JUST_BIT];
      flag_next = sfr_wdata[ARFWD_FLAG_BIT];
    end
    // a finished conversion overrides a same-cycle data write
    if (conv_done) begin
      res_hi_next = new_word[15:8];
      res_lo_next = new_word[7:0];
    end
    // set beats a same-cycle clear
    if (hit) begin
      flag_next = 1'b1;
    end
    // registered read data
    if (sfr_rd) begin
      if (addr_is(sfr_addr, ARFWD_RES_LO_ADDR)) begin
        rdata_next = res_lo_reg;
      end else if (addr_is(sfr_addr, ARFWD_RES_HI_ADDR)) begin
        rdata_next = res_hi_reg;
      end else if (addr_is(sfr_addr, ARFWD_UPL_LO_ADDR)) begin
        rdata_next = upl_lo_reg;
      end else if (addr_is(sfr_addr, ARFWD_UPL_HI_ADDR)) begin
        rdata_next = upl_hi_reg;
      end else if (addr_is(sfr_addr, ARFWD_LWL_LO_ADDR)) begin
        rdata_next = lwl_lo_reg;
      end else if (addr_is(sfr_addr, ARFWD_LWL_HI_ADDR)) begin
        rdata_next = lwl_hi_reg;
      end else if (addr_is(sfr_addr, ARFWD_CTRL_ADDR)) begin
        rdata_next = {6'h00, flag_reg, just_reg};
      end else begin
        rdata_next = ARFWD_UNMAPPED_VAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_lo_reg <= ARFWD_RES_LO_RST;
      res_hi_reg <= ARFWD_RES_HI_RST;
      upl_lo_reg <= ARFWD_UPL_LO_RST;
      upl_hi_reg <= ARFWD_UPL_HI_RST;
      lwl_lo_reg <= ARFWD_LWL_LO_RST;
      lwl_hi_reg <= ARFWD_LWL_HI_RST;
      just_reg   <= 1'b0;
      flag_reg   <= 1'b0;
      rdata_reg  <= ARFWD_RDATA_RST;
    end else begin
      res_lo_reg <= res_lo_next;
      res_hi_reg <= res_hi_next;
      upl_lo_reg <= upl_lo_next;
      upl_hi_reg <= upl_hi_next;
      lwl_lo_reg <= lwl_lo_next;
      lwl_hi_reg <= lwl_hi_next;
      just_reg   <= just_next;
      flag_reg   <= flag_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign sfr_rdata         = rdata_reg;
  assign justify_left_sel  = just_reg;
  assign window_match_flag = flag_reg;

  // data layout checks
  rj_sign_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !just_reg && conv_diff
    |=> res_hi_reg == {{6{$past(conv_data[9])}}, $past(conv_data[9:8])})
    else $error("right justified sign extension wrong");

  rj_zero_fill_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !just_reg && !conv_diff
    |=> res_hi_reg == {6'h00, $past(conv_data[9:8])})
    else $error("right justified upper bits not zero");

  rj_low_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !just_reg
    |=> res_lo_reg == $past(conv_data[7:0]))
    else $error("right justified low byte wrong");

  lj_high_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && just_reg
    |=> res_hi_reg == $past(conv_data[9:2]))
    else $error("left justified high byte wrong");

  lj_low_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && just_reg
    |=> res_lo_reg == {$past(conv_data[1:0]), 6'h00})
    else $error("left justified low byte wrong");

  se_full_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !conv_diff && conv_data == 10'h3ff
    |=> {res_hi_reg, res_lo_reg} == ($past(just_reg) ? 16'hffc0 : 16'h03ff))
    else $error("single-ended full scale code wrong");

  diff_neg_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && conv_diff && conv_data == 10'h200
    |=> {res_hi_reg, res_lo_reg} == ($past(just_reg) ? 16'h8000 : 16'hfe00))
    else $error("differential negative full scale code wrong");

  // window flag, compare, control, layout and limit write checks
  match_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && win_match |=> window_match_flag)
    else $error("window match did not set flag");

  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    window_match_flag && !ctrl_wr |=> window_match_flag [*2] or ctrl_wr ##1 1'b1)
    else $error("window flag dropped without software clear");

  no_match_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !win_match && !ctrl_wr
    |=> window_match_flag == $past(window_match_flag))
    else $error("unmatched result changed flag");

  sw_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr && !sfr_wdata[1] && !hit |=> !window_match_flag)
    else $error("software clear of flag failed");

  justify_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> justify_left_sel == $past(sfr_wdata[0]))
    else $error("justify control not taken");

  inband_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !conv_diff && !just_reg
    && {lwl_hi_reg, lwl_lo_reg} == 16'h0200 && {upl_hi_reg, upl_lo_reg} == 16'h0100
    && conv_data == 10'h180 |-> win_match)
    else $error("in-band result not matched");

  outband_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !conv_diff && !just_reg
    && {lwl_hi_reg, lwl_lo_reg} == 16'h0100 && {upl_hi_reg, upl_lo_reg} == 16'h0200
    && conv_data == 10'h180 |-> !win_match)
    else $error("in-band result matched in out-of-band mode");

  signed_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && conv_diff && !just_reg
    && {lwl_hi_reg, lwl_lo_reg} == 16'h0100 && {upl_hi_reg, upl_lo_reg} == 16'hffff
    && conv_data == 10'h000 |-> win_match)
    else $error("signed compare failed for zero");

  signed_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && conv_diff && !just_reg
    && {lwl_hi_reg, lwl_lo_reg} == 16'h0100 && {upl_hi_reg, upl_lo_reg} == 16'hffff
    && conv_data == 10'h3ff |-> !win_match)
    else $error("signed compare matched minus one");

  se_half_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !conv_diff && conv_data == 10'h200
    |=> {res_hi_reg, res_lo_reg} == ($past(just_reg) ? 16'h8000 : 16'h0200))
    else $error("single-ended half scale code wrong");

  diff_max_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && conv_diff && conv_data == 10'h1ff
    |=> {res_hi_reg, res_lo_reg} == ($past(just_reg) ? 16'h7fc0 : 16'h01ff))
    else $error("differential positive full scale code wrong");

  diff_minus_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && conv_diff && conv_data == 10'h3ff
    |=> {res_hi_reg, res_lo_reg} == ($past(just_reg) ? 16'hffc0 : 16'hffff))
    else $error("differential minus one code wrong");

  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hit && !ctrl_wr |=> window_match_flag == $past(window_match_flag))
    else $error("window flag changed without cause");

  flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ARFWD_CTRL_ADDR
    |=> sfr_rdata == {6'h00, $past(window_match_flag), $past(justify_left_sel)})
    else $error("control read does not show flag");

  upper_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ARFWD_UPL_HI_ADDR |=> upl_hi_reg == $past(sfr_wdata))
    else $error("upper limit high byte not written");

  lower_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ARFWD_LWL_LO_ADDR |=> lwl_lo_reg == $past(sfr_wdata))
    else $error("lower limit low byte not written");

endmodule

`default_nettype wire

/* rtl/arfwd_pkg.sv */
package arfwd_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] ARFWD_RES_LO_ADDR  = 8'hbe;
  localparam logic [7:0] ARFWD_RES_HI_ADDR  = 8'hbf;
  localparam logic [7:0] ARFWD_UPL_LO_ADDR  = 8'hc4;
  localparam logic [7:0] ARFWD_UPL_HI_ADDR  = 8'hc5;
  localparam logic [7:0] ARFWD_LWL_LO_ADDR  = 8'hc6;
  localparam logic [7:0] ARFWD_LWL_HI_ADDR  = 8'hc7;
  localparam logic [7:0] ARFWD_CTRL_ADDR    = 8'he8;

  // converter control register fields held here
  localparam int         ARFWD_JUST_BIT     = 0;
  localparam int         ARFWD_FLAG_BIT     = 1;

  // reset values
  localparam logic [7:0] ARFWD_RES_LO_RST   = 8'h00;
  localparam logic [7:0] ARFWD_RES_HI_RST   = 8'h00;
  localparam logic [7:0] ARFWD_UPL_LO_RST   = 8'hff;
  localparam logic [7:0] ARFWD_UPL_HI_RST   = 8'hff;
  localparam logic [7:0] ARFWD_LWL_LO_RST   = 8'h00;
  localparam logic [7:0] ARFWD_LWL_HI_RST   = 8'h00;
  localparam logic [7:0] ARFWD_RDATA_RST    = 8'h00;
  localparam logic [7:0] ARFWD_UNMAPPED_VAL = 8'h00;

  // result layout
  localparam int         ARFWD_RES_W        = 10;
  localparam int         ARFWD_WORD_W       = 16;
  localparam int         ARFWD_PAD_W        = ARFWD_WORD_W - ARFWD_RES_W;

  typedef logic [ARFWD_WORD_W-1:0] arfwd_word_type;

endpackage

/* rtl/arfwd_window_cmp.sv */
`timescale 1ns/1ns
`default_nettype none

module arfwd_window_cmp
  import arfwd_pkg::*;
(
  input  wire logic [ARFWD_WORD_W-1:0] data_word,
  input  wire logic [ARFWD_WORD_W-1:0] upper_limit,
  input  wire logic [ARFWD_WORD_W-1:0] lower_limit,
  input  wire logic                    signed_cmp,
  output logic                         match
);

  logic signed [ARFWD_WORD_W:0] data_ext;
  logic signed [ARFWD_WORD_W:0] upper_ext;
  logic signed [ARFWD_WORD_W:0] lower_ext;
  logic                         below_lower;
  logic                         above_upper;

  // one extra bit turns both number kinds into one signed compare
  always_comb begin
    data_ext    = {signed_cmp & data_word[ARFWD_WORD_W-1], data_word};
    upper_ext   = {signed_cmp & upper_limit[ARFWD_WORD_W-1], upper_limit};
    lower_ext   = {signed_cmp & lower_limit[ARFWD_WORD_W-1], lower_limit};
    below_lower = data_ext < lower_ext;
    above_upper = data_ext > upper_ext;
    if (lower_ext > upper_ext) begin
      match = below_lower && above_upper;
    end else begin
      match = below_lower || above_upper;
    end
  end

endmodule

`default_nettype wire

/* tb/arfwd_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none

module arfwd_conv_model
  import arfwd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   req,
  input  wire logic [ARFWD_RES_W-1:0] req_data,
  input  wire logic                   req_diff,
  output logic                        conv_done,
  output logic      [ARFWD_RES_W-1:0] conv_data,
  output logic                        conv_diff
);
  // one-cycle end of conversion; data scrambled outside it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_done <= 1'b0;
      conv_data <= 10'h155;
      conv_diff <= 1'b0;
    end else begin
      conv_done <= req;
      conv_data <= req ? req_data : ~conv_data;
      conv_diff <= req ? req_diff : ~conv_diff;
    end
  end
endmodule

`default_nettype wire

/* tb/arfwd_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module arfwd_core_tb
  import arfwd_pkg::*;
;
  typedef struct {string name; logic [7:0] val;} arfwd_note_type;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   sfr_wr = 1'b0;
  logic                   sfr_rd = 1'b0;
  logic                   req = 1'b0;
  logic                   req_diff = 1'b0;
  logic [7:0]             sfr_addr = 8'h00;
  logic [7:0]             sfr_wdata = 8'h00;
  logic [9:0]             req_data = 10'h000;
  logic                   conv_done;
  logic                   conv_diff;
  logic [9:0]             conv_data;
  logic [7:0]             sfr_rdata;
  logic                   justify_left_sel;
  logic                   window_match_flag;
  arfwd_word_type         lt_m;
  arfwd_word_type         gt_m;
  arfwd_word_type         res_m;
  logic                   left_m;
  logic                   flag_m;
  arfwd_note_type         notes[$];
  int                     miscompares = 0;
  int                     tests_run = 0;
  logic [9:0]             t_raw[5] = '{10'h3ff, 10'h200, 10'h1ff, 10'h3ff, 10'h200};
  logic                   t_dif[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  arfwd_word_type         t_rgt[5] = '{16'h03ff, 16'h0200, 16'h01ff, 16'hffff, 16'hfe00};
  arfwd_word_type         t_lft[5] = '{16'hffc0, 16'h8000, 16'h7fc0, 16'hffc0, 16'h8000};

  always #5 clk = ~clk;

  arfwd_conv_model arfwd_conv_model_inst (.clk(clk), .rst_n(rst_n), .req(req), .req_data(req_data),
    .req_diff(req_diff), .conv_done(conv_done), .conv_data(conv_data), .conv_diff(conv_diff));
  arfwd_core arfwd_core_inst (.clk(clk), .rst_n(rst_n), .conv_done(conv_done), .conv_data(conv_data),
    .conv_diff(conv_diff), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .justify_left_sel(justify_left_sel), .window_match_flag(window_match_flag));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // read data compared on the falling edge after the clock edge that samples the strobe
  always @(posedge clk) begin
    arfwd_note_type n;
    if (sfr_rd === 1'b1) begin
      @(negedge clk);
      n = notes.pop_front();
      chk(n.name, {8'h00, n.val}, {8'h00, sfr_rdata});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    notes.push_back(arfwd_note_type'{n, e});
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask

  task automatic ctl(input logic l, input logic f);
    wr(ARFWD_CTRL_ADDR, {6'h00, f, l});
    left_m = l;
    flag_m = f;
  endtask

  task automatic setlim(input arfwd_word_type lt, input arfwd_word_type gt);
    wr(ARFWD_LWL_HI_ADDR, lt[15:8]);
    wr(ARFWD_UPL_LO_ADDR, gt[7:0]);
    wr(ARFWD_LWL_LO_ADDR, lt[7:0]);
    wr(ARFWD_UPL_HI_ADDR, gt[15:8]);
    lt_m = lt;
    gt_m = gt;
    rd(ARFWD_LWL_LO_ADDR, lt[7:0], "lower low");
    rd(ARFWD_LWL_HI_ADDR, lt[15:8], "lower high");
    rd(ARFWD_UPL_LO_ADDR, gt[7:0], "upper low");
    rd(ARFWD_UPL_HI_ADDR, gt[15:8], "upper high");
  endtask

  function automatic arfwd_word_type fmt(input logic [9:0] r, input logic l, input logic d);
    return l ? {r, 6'h00} : {{6{d & r[9]}}, r};
  endfunction

  function automatic logic win(input arfwd_word_type w, input arfwd_word_type lt, input arfwd_word_type gt,
                               input logic sg);
    if (sg) begin
      return ($signed(lt) > $signed(gt)) ? ($signed(w) < $signed(lt) && $signed(w) > $signed(gt))
                                         : ($signed(w) < $signed(lt) || $signed(w) > $signed(gt));
    end
    return (lt > gt) ? (w < lt && w > gt) : (w < lt || w > gt);
  endfunction

  task automatic conv(input logic [9:0] r, input logic d);
    @(posedge clk);
    req <= 1'b1;
    req_data <= r;
    req_diff <= d;
    @(posedge clk);
    req <= 1'b0;
    res_m = fmt(r, left_m, d);
    if (win(res_m, lt_m, gt_m, d)) flag_m = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("match flag", {15'h0, flag_m}, {15'h0, window_match_flag});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    complete_run();
  end

  initial begin
    logic [31:0]    s;
    arfwd_word_type w;
    s = $urandom(32'h9766);
    lt_m = {ARFWD_LWL_HI_RST, 8'h00};
    gt_m = {8'hff, ARFWD_UPL_LO_RST};
    left_m = 1'b0;
    flag_m = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ARFWD_RES_LO_ADDR, 8'h00, "result low");
    rd(ARFWD_RES_HI_ADDR, 8'h00, "result high");
    rd(ARFWD_LWL_LO_ADDR, 8'h00, "lower low");
    rd(ARFWD_UPL_HI_ADDR, 8'hff, "upper high");
    rd(ARFWD_CTRL_ADDR, 8'h00, "control");
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      ctl(i[0], 1'b0);
      conv(t_raw[i/2], t_dif[i/2]);
      w = i[0] ? t_lft[i/2] : t_rgt[i/2];
      rd(ARFWD_RES_LO_ADDR, w[7:0], "result low");
      rd(ARFWD_RES_HI_ADDR, w[15:8], "result high");
      chk("justify", {15'h0, i[0]}, {15'h0, justify_left_sel});
    end
    $display("test format done");
    setlim(16'h0200, 16'h0100);
    ctl(1'b0, 1'b0);
    conv(10'h100, 1'b0);
    conv(10'h101, 1'b0);
    conv(10'h180, 1'b0);
    setlim(16'h0100, 16'h0200);
    ctl(1'b0, 1'b0);
    conv(10'h150, 1'b0);
    conv(10'h180, 1'b0);
    conv(10'h201, 1'b0);
    conv(10'h150, 1'b0);
    rd(ARFWD_CTRL_ADDR, {6'h00, flag_m, left_m}, "control");
    setlim(16'h0100, 16'hffff);
    ctl(1'b0, 1'b0);
    conv(10'h3ff, 1'b1);
    conv(10'h000, 1'b1);
    $display("test window done");
    repeat (150) begin
      setlim(16'($urandom), 16'($urandom));
      ctl(1'($urandom), 1'($urandom));
      conv(10'($urandom), 1'($urandom));
      rd(ARFWD_RES_LO_ADDR, res_m[7:0], "result low");
      rd(ARFWD_RES_HI_ADDR, res_m[15:8], "result high");
      rd(ARFWD_CTRL_ADDR, {6'h00, flag_m, left_m}, "control");
    end
    $display("test random done");
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule

`default_nettype wire
